/* i2c_pending_access.sv */
// I2C slave with sub-address pointer, pending writes committed on STOP, and status snapshots
// Notes on behaviour
// - Ack write address, next byte is sub-address
// - Pointer loads when sub-address ack is driven
// - Data pair stored when the high byte's ack is driven
// - Sub-address and pair may repeat indefinitely
// - Keep latest pending data until STOP
// - STOP copies all pending into command registers
// - Read returns only register at current pointer
// - Ack read address, send low byte first
// - Release line in ack slots and after
// - Never acknowledge data bytes in a read
// - Write-only read shows pending if modified
// - Read-write register reads committed value
// - Status snapshot taken at read-address ack
// - Busy at ack reports previous finished result
// - Alarm drives interrupt low, freezes C[3:0]
// - Clearing interrupt releases cause, snapshots resume
// - Respond to address 1100100, LSB selects direction
// - Two bytes, low first, MSB first
// - Never drive or stretch the clock line
`timescale 1ns/1ps
`default_nettype none

module i2c_pending_access (
    input  wire logic                         clock_in,       // 100 MHz system clock
    input  wire logic                         reset_in,       // Synchronous reset, active high
    input  wire logic                         scl_in,         // Serial clock pin level
    input  wire logic                         sda_in,         // Serial data pin level
    output var  logic                         sda_out,        // Data value when driven, always low
    output var  logic                         sda_oe_out,     // High while pulling data low
    input  wire i2c_access_pkg::status_bank_t status_live_in, // Live status from engines
    input  wire logic                         busy_in,        // Conversion or current pulse running
    input  wire logic                         done_in,        // Conversion or pulse finished, pulse
    input  wire logic                         alarm_in,       // Alarm or fault event, pulse
    input  wire logic                         irq_clear_in,   // Interrupt cleared by master, pulse
    output var  i2c_access_pkg::cmd_bank_t    cmd_out,        // Command registers in effect
    output var  logic                         commit_out,     // One-cycle pulse on STOP commit
    output var  logic                         irq_n_out       // Interrupt request, active low
);

    import i2c_access_pkg::*;

    // Filtered pin levels and their previous values
    logic         scl_f;                             // Filtered clock level
    logic         sda_f;                             // Filtered data level
    logic         scl_p_q;                           // Clock level one cycle earlier
    logic         sda_p_q;                           // Data level one cycle earlier
    logic         scl_rise;                          // Clock rising edge
    logic         scl_fall;                          // Clock falling edge
    logic         start_det;                         // START or repeated START
    logic         stop_det;                          // STOP

    // Protocol engine
    i2c_state_t   state_q;                           // Current state
    logic [3:0]   bit_cnt_q;                         // Bits seen in the current frame
    logic [7:0]   rx_q;                              // Receive shift register
    logic [7:0]   ptr_q;                             // Sub-address pointer
    logic [7:0]   low_byte_q;                        // First data byte of a pair
    logic         second_q;                          // Next data byte is the high byte
    logic [15:0]  tx_q;                              // Transmit shift register
    logic         tx_second_q;                       // Second read byte in progress

    // Pending and committed words
    cmd_bank_t    pend_q;                            // Pending command words
    logic [2:0]   mod_q;                             // Modified since STOP: a, b, h
    logic         pair_done;                         // Data pair acknowledged this cycle

    // Status snapshot and interrupt
    status_bank_t snap_q;                            // Last status snapshot
    logic [CAUSE_BITS-1:0] cause_q;                  // Frozen cause bits
    logic         irq_q;                             // Interrupt pending
    logic         rd_ack;                            // Read address acknowledged this cycle
    status_bank_t view;                              // Status visible to a read
    logic [15:0]  rd_word;                           // Word selected for a read

    // Both lines are sampled through filters; the clock pin has no output at all
    pin_filter #(.RESET_LEVEL(1'b1)) scl_filt (
        .clock_in  (clock_in),
        .reset_in  (reset_in),
        .pin_in    (scl_in),
        .level_out (scl_f)
    );

    pin_filter #(.RESET_LEVEL(1'b1)) sda_filt (
        .clock_in  (clock_in),
        .reset_in  (reset_in),
        .pin_in    (sda_in),
        .level_out (sda_f)
    );

    // Previous levels for edge detection
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // Bus events
    always_comb begin
        scl_rise  = scl_f & ~scl_p_q;
        scl_fall  = ~scl_f & scl_p_q;
        start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
        stop_det  = scl_f & scl_p_q & ~sda_p_q & sda_f;
    end

    // Address match at the end of the address frame
    logic addr_hit;                                  // Address bits equal ours
    always_comb begin
        addr_hit  = (rx_q[7:1] == DEV_ADDR);
        rd_ack    = (state_q == ST_ADDR) && scl_fall && (bit_cnt_q == BIT_CNT_FULL) && addr_hit && rx_q[0];
        pair_done = (state_q == ST_DATA) && scl_fall && (bit_cnt_q == BIT_CNT_FULL) && second_q;
    end

    // Status seen by a read: live at ack unless an engine is busy
    always_comb begin
        view = snap_q;
        if (rd_ack && !busy_in) begin
            view = status_live_in;
        end
        if (irq_q) begin
            view.c[CAUSE_BITS-1:0] = cause_q;
        end
    end

    // Word returned for the current pointer
    always_comb begin
        case (ptr_q)
            SUB_A:   rd_word = mod_q[2] ? pend_q.a : cmd_out.a;
            SUB_B:   rd_word = cmd_out.b;
            SUB_H:   rd_word = mod_q[0] ? pend_q.h : cmd_out.h;
            SUB_C:   rd_word = view.c;
            SUB_D:   rd_word = view.d;
            SUB_E:   rd_word = view.e;
            SUB_F:   rd_word = view.f;
            SUB_G:   rd_word = view.g;
            default: rd_word = UNMAPPED_VAL;
        endcase
    end

    // Protocol state machine
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_q     <= ST_IDLE;
            bit_cnt_q   <= 4'h0;
            second_q    <= 1'b0;
            tx_second_q <= 1'b0;
        end else if (start_det) begin
            // A START abandons any half pair without storing it
            state_q   <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            second_q  <= 1'b0;
        end else if (stop_det) begin
            state_q   <= ST_IDLE;
            second_q  <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_SUB, ST_DATA: begin
                    // Count bits on rising edges
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == BIT_CNT_FULL) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == ST_ADDR) begin
                            state_q <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
                        end else if (state_q == ST_SUB) begin
                            state_q <= ST_SUB_ACK;
                        end else begin
                            state_q <= ST_DATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    // Address ack ends; read goes straight to transmit
                    if (scl_fall) begin
                        state_q     <= rx_q[0] ? ST_RD : ST_SUB;
                        tx_second_q <= 1'b0;
                    end
                end
                ST_SUB_ACK: begin
                    if (scl_fall) begin
                        state_q  <= ST_DATA;
                        second_q <= 1'b0;
                    end
                end
                ST_DATA_ACK: begin
                    // After the high byte a new sub-address follows
                    if (scl_fall) begin
                        state_q  <= second_q ? ST_DATA : ST_SUB;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == BIT_CNT_FULL) begin
                        bit_cnt_q <= 4'h0;
                        state_q   <= ST_RD_SLOT;
                    end
                end
                ST_RD_SLOT: begin
                    // Master ack or nack has no consequence
                    if (scl_fall) begin
                        state_q     <= tx_second_q ? ST_RD_DONE : ST_RD;
                        tx_second_q <= 1'b1;
                    end
                end
                ST_RD_DONE: begin
                    state_q <= ST_RD_DONE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            // Track which byte of a pair comes next
            if (state_q == ST_DATA && scl_fall && bit_cnt_q == BIT_CNT_FULL) begin
                second_q <= ~second_q;
            end
        end
    end

    // Receive shift register, MSB first
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rx_q <= 8'h00;
        end else if (scl_rise && (state_q == ST_ADDR || state_q == ST_SUB || state_q == ST_DATA)) begin
            rx_q <= {rx_q[6:0], sda_f};
        end
    end

    // Pointer and first data byte
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ptr_q      <= PTR_RESET;
            low_byte_q <= 8'h00;
        end else if (scl_fall && bit_cnt_q == BIT_CNT_FULL) begin
            if (state_q == ST_SUB) begin
                ptr_q <= rx_q;
            end else if (state_q == ST_DATA && !second_q) begin
                low_byte_q <= rx_q;
            end
        end
    end

    // Pending words and their modified flags
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pend_q <= '{a: CMD_RESET, b: CMD_RESET, h: CMD_RESET};
            mod_q  <= 3'b000;
        end else if (stop_det) begin
            mod_q <= 3'b000;
        end else if (pair_done) begin
            // Latest pair wins for each location
            case (ptr_q)
                SUB_A: begin
                    pend_q.a <= {rx_q, low_byte_q};
                    mod_q[2] <= 1'b1;
                end
                SUB_B: begin
                    pend_q.b <= {rx_q, low_byte_q};
                    mod_q[1] <= 1'b1;
                end
                SUB_H: begin
                    pend_q.h <= {rx_q, low_byte_q};
                    mod_q[0] <= 1'b1;
                end
                default: begin
                    mod_q <= mod_q;
                end
            endcase
        end
    end

    // Command registers update only on STOP
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            cmd_out    <= '{a: CMD_RESET, b: CMD_RESET, h: CMD_RESET};
            commit_out <= 1'b0;
        end else begin
            commit_out <= stop_det;
            if (stop_det) begin
                cmd_out <= pend_q;
            end
        end
    end

    // Transmit shift register, low byte first, MSB first
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            tx_q <= 16'h0000;
        end else if (rd_ack) begin
            tx_q <= {rd_word[7:0], rd_word[15:8]};
        end else if (state_q == ST_RD && scl_fall && bit_cnt_q != 4'h0 && bit_cnt_q != BIT_CNT_FULL) begin
            tx_q <= {tx_q[14:0], 1'b0};
        end else if (state_q == ST_RD_SLOT && scl_fall) begin
            tx_q <= {tx_q[14:0], 1'b0};
        end
    end

    // Data line driver, open drain
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            sda_oe_out <= 1'b0;
            sda_out    <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_out <= 1'b0;
        end else if (scl_fall) begin
            case (state_q)
                ST_ADDR:     sda_oe_out <= (bit_cnt_q == BIT_CNT_FULL) && addr_hit;
                ST_SUB:      sda_oe_out <= (bit_cnt_q == BIT_CNT_FULL);
                ST_DATA:     sda_oe_out <= (bit_cnt_q == BIT_CNT_FULL);
                ST_ADDR_ACK: sda_oe_out <= rx_q[0] && !tx_q[15];
                ST_RD: begin
                    // Never ack in a read; release after the eighth bit
                    if (bit_cnt_q == BIT_CNT_FULL) begin
                        sda_oe_out <= 1'b0;
                    end else if (bit_cnt_q != 4'h0) begin
                        sda_oe_out <= !tx_q[14];
                    end
                end
                ST_RD_SLOT:  sda_oe_out <= !tx_second_q && !tx_q[14];
                default:     sda_oe_out <= 1'b0;
            endcase
        end
    end

    // Status snapshot at ack, engine completion or interrupt
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            snap_q <= '0;
        end else if ((rd_ack && !busy_in) || done_in || alarm_in) begin
            snap_q <= status_live_in;
        end
    end

    // Interrupt flag and frozen cause; a new alarm wins over a clear
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            irq_q     <= 1'b0;
            cause_q   <= '0;
            irq_n_out <= 1'b1;
        end else begin
            if (alarm_in && !irq_q) begin
                irq_q   <= 1'b1;
                cause_q <= status_live_in.c[CAUSE_BITS-1:0];
            end else if (alarm_in) begin
                irq_q   <= 1'b1;
            end else if (irq_clear_in) begin
                irq_q   <= 1'b0;
                cause_q <= '0;
            end
            // Pin follows the flag's next value, so a clear shows one edge later just as an alarm does
            irq_n_out <= ~(alarm_in | (irq_q & ~irq_clear_in));
        end
    end

endmodule : i2c_pending_access

`default_nettype wire

/* i2c_access_pkg.sv */
// Shared constants and types for the I2C pending-register access block
package i2c_access_pkg;

    // Bus addressing
    localparam logic [6:0] DEV_ADDR      = 7'h64;   // Seven-bit slave address 1100100
    localparam int         BYTE_BITS     = 8;       // Bits per frame
    localparam logic [3:0] BIT_CNT_FULL  = 4'h8;    // Bit count at the end of a frame
    localparam int         WORD_BITS     = 16;      // Every register transfer is two bytes

    // Sub-address pointer values
    localparam logic [7:0] SUB_A         = 8'h01;   // Write-only command register A
    localparam logic [7:0] SUB_B         = 8'h02;   // Read-write control register B
    localparam logic [7:0] SUB_C         = 8'h03;   // Status register C
    localparam logic [7:0] SUB_D         = 8'h04;   // Status register D
    localparam logic [7:0] SUB_E         = 8'h05;   // Status register E
    localparam logic [7:0] SUB_F         = 8'h06;   // Status register F
    localparam logic [7:0] SUB_G         = 8'h07;   // Status register G
    localparam logic [7:0] SUB_H         = 8'h08;   // Write-only command register H

    // Reset values
    localparam logic [7:0]  PTR_RESET    = 8'h00;   // Pointer after reset
    localparam logic [15:0] CMD_RESET    = 16'h0000; // Command and pending words after reset
    localparam logic [15:0] UNMAPPED_VAL = 16'h0000; // Read value of an unused pointer
    localparam int          CAUSE_BITS   = 4;       // Latched interrupt cause field C[3:0]

    // Read-only status words as sampled from the measurement engines
    typedef struct packed {
        logic [15:0] c;                              // Status C
        logic [15:0] d;                              // Status D
        logic [15:0] e;                              // Status E
        logic [15:0] f;                              // Status F
        logic [15:0] g;                              // Status G
    } status_bank_t;

    // Writable command words
    typedef struct packed {
        logic [15:0] a;                              // Command A
        logic [15:0] b;                              // Control B
        logic [15:0] h;                              // Command H
    } cmd_bank_t;

    // Protocol engine states
    typedef enum logic [3:0] {
        ST_IDLE,                                     // Waiting for START
        ST_ADDR,                                     // Receiving address byte
        ST_ADDR_ACK,                                 // Driving address acknowledge
        ST_SUB,                                      // Receiving sub-address
        ST_SUB_ACK,                                  // Driving sub-address acknowledge
        ST_DATA,                                     // Receiving a data byte
        ST_DATA_ACK,                                 // Driving data acknowledge
        ST_RD,                                       // Shifting out a read byte
        ST_RD_SLOT,                                  // Released line in master ack slot
        ST_RD_DONE                                   // Line held released until START/STOP
    } i2c_state_t;

endpackage : i2c_access_pkg

/* pin_filter.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_filter #(
    parameter logic RESET_LEVEL = 1'b1                // Level shown during reset
) (
    input  wire logic clock_in,                      // System clock
    input  wire logic reset_in,                      // Synchronous reset, active high
    input  wire logic pin_in,                        // Asynchronous pin level
    output var  logic level_out                      // Filtered level
);

    logic stage1_q;                                  // First stage, read only by stage two
    logic stage2_q;                                  // Second stage
    logic stage3_q;                                  // Third stage

    // Synchroniser chain
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            stage1_q <= RESET_LEVEL;
            stage2_q <= RESET_LEVEL;
            stage3_q <= RESET_LEVEL;
        end else begin
            stage1_q <= pin_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // Accept a change only once stages two and three agree
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            level_out <= RESET_LEVEL;
        end else if (stage2_q == stage3_q) begin
            level_out <= stage3_q;
        end
    end

endmodule : pin_filter

`default_nettype wire

/* access_checker_asserts.sv */
// Port-level assertions for the pending-access block
`timescale 1ns/1ps
`default_nettype none
module access_checker (
    input wire logic                      clock_in,
    input wire logic                      reset_in,
    input wire logic                      scl_in,
    input wire logic                      sda_in,
    input wire logic                      sda_out,
    input wire logic                      sda_oe_out,
    input wire logic                      alarm_in,
    input wire logic                      irq_clear_in,
    input wire i2c_access_pkg::cmd_bank_t cmd_out,
    input wire logic                      commit_out,
    input wire logic                      irq_n_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    // Bus idle, both lines high
    sequence s_idle; scl_in && sda_in; endsequence
    // Pull held over a bus phase
    sequence s_held; sda_oe_out [*8]; endsequence
    a_commit_pulse:
        assert property (commit_out |=> !commit_out) else $error("commit wider than one cycle");
    a_commit_stop:
        assert property (commit_out |-> s_idle) else $error("commit without stop");
    a_cmd_steady:
        assert property (!commit_out |-> $stable(cmd_out)) else $error("commands moved without commit");
    a_ack_held:
        assert property ($rose(sda_oe_out) |=> s_held) else $error("data pull too short");
    a_oe_scl_low:
        assert property ($changed(sda_oe_out) |-> !scl_in) else $error("data changed with clock high");
    a_sda_low:
        assert property (sda_out == 1'b0) else $error("data driven high");
    a_irq_set:
        assert property (alarm_in |=> !irq_n_out) else $error("alarm not raised");
    a_irq_clear:
        assert property (irq_clear_in && !alarm_in |=> irq_n_out) else $error("interrupt not cleared");
    a_irq_hold:
        assert property (!irq_n_out && !irq_clear_in |=> !irq_n_out) else $error("interrupt dropped");
    a_irq_quiet:
        assert property (irq_n_out && !alarm_in |=> irq_n_out) else $error("interrupt without alarm");
endmodule : access_checker
bind i2c_pending_access access_checker access_checker_i (.*);
`default_nettype wire

/* i2c_master_model.sv */
// Behavioural bus master: drives the clock, pulls data low
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input  wire logic clock_in,   // Bench clock
    input  wire logic sda_in,     // Resolved data line
    output var  logic scl_out,    // Clock line, idle high
    output var  logic sda_oe_out  // High while pulling data low
);
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // Set both lines and hold them n cycles
    task automatic drv(input logic c, input logic d, input int n);
        scl_out = c;
        sda_oe_out = !d;
        repeat (n) @(negedge clock_in);
    endtask : drv
    // START, or repeated START
    task automatic start();
        drv(1'b0, !sda_oe_out, 5);
        drv(1'b0, 1'b1, 15);
        drv(1'b1, 1'b1, 20);
        drv(1'b1, 1'b0, 20);
    endtask : start
    // STOP ends a write or a read
    task automatic stop();
        drv(1'b0, !sda_oe_out, 5);
        drv(1'b0, 1'b0, 15);
        drv(1'b1, 1'b0, 20);
        drv(1'b1, 1'b1, 20);
    endtask : stop
    // Eight bits MSB first, then a released acknowledge slot
    task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic [8:0] v;
        v = {d, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            drv(1'b0, !sda_oe_out, 5);
            drv(1'b0, v[i], 15);
            drv(1'b1, v[i], 20);
            if (i > 0) r[i-1] = sda_in;
            else ack = sda_in;
        end
    endtask : xbyte
endmodule : i2c_master_model
`default_nettype wire

/* i2c_pending_access_test.sv */
// Self-checking bench for the pending-access block
`timescale 1ns/1ps
`default_nettype none
module i2c_pending_access_test;
    import i2c_access_pkg::*;
    logic clock_in, reset_in, busy_in, done_in, alarm_in, irq_clear_in;  // Design inputs
    logic sda_out, sda_oe_out, commit_out, irq_n_out, scl, m_oe, a;     // Outputs and ack
    wire logic sda = !(sda_oe_out || m_oe);                             // Pulled-up data line
    status_bank_t live, keep;                                           // Live and expected status
    cmd_bank_t cmd_out, cmd_exp;                                        // Commands seen and expected
    logic [31:0] seed = 32'hd1b24627;                                   // Random state
    logic [7:0] q;                                                      // Byte read
    int error_cnt, checks, cyc;                                         // Counters
    i2c_pending_access i2c_pending_access_i (.clock_in(clock_in), .reset_in(reset_in), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .status_live_in(live), .busy_in(busy_in),
        .done_in(done_in), .alarm_in(alarm_in), .irq_clear_in(irq_clear_in), .cmd_out(cmd_out),
        .commit_out(commit_out), .irq_n_out(irq_n_out));
    i2c_master_model i2c_master_model_i (.clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // Hang guard
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            end_sim();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic end_sim();
        if (error_cnt == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // Byte the device must acknowledge
    task automatic ad(input logic [7:0] d);
        i2c_master_model_i.xbyte(d, q, a);
        chk("ack", 0, a);
    endtask : ad
    // Write address then sub-address
    task automatic ptr(input logic [7:0] s);
        i2c_master_model_i.start();
        ad(8'hc8);
        ad(s);
    endtask : ptr
    task automatic pair(input logic [15:0] w);
        ad(w[7:0]);
        ad(w[15:8]);
    endtask : pair
    // Read a word and one trailing frame
    task automatic rd(input logic [15:0] e);
        logic [7:0] lo, hi;
        logic al, ah;
        i2c_master_model_i.start();
        ad(8'hc9);
        i2c_master_model_i.xbyte(8'hff, lo, al);
        i2c_master_model_i.xbyte(8'hff, hi, ah);
        chk("word", e, {hi, lo});
        i2c_master_model_i.xbyte(8'hff, q, a);
        chk("release", 11'h7ff, {al, ah, q, a});
    endtask : rd
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock_in);
        s = 1'b0;
    endtask : pulse
    initial begin
        logic [15:0] va, vb, vh;
        {reset_in, busy_in, done_in, alarm_in, irq_clear_in} = 5'h10;
        live = '0;
        cmd_exp = '0;
        repeat (8) @(negedge clock_in);
        reset_in = 1'b0;
        repeat (8) @(negedge clock_in);
        for (int k = 0; k < 2; k++) begin
            va = 16'(rnd());
            vb = 16'(rnd());
            vh = 16'(rnd());
            ptr(SUB_A);
            pair(va);
            ad(SUB_B);
            pair(vb);
            ad(SUB_H);
            pair(vh);
            ad(SUB_B);
            rd(cmd_exp.b);
            chk("cmd", cmd_exp, cmd_out);
            ptr(SUB_A);
            rd(va);
            i2c_master_model_i.stop();
            cmd_exp = {va, vb, vh};
            chk("cmd", cmd_exp, cmd_out);
            ptr(SUB_B);
            rd(vb);
            ptr(SUB_H);
            ad(8'(rnd()));
            i2c_master_model_i.stop();
            rd(vh);
            chk("cmd", cmd_exp, cmd_out);
        end
        i2c_master_model_i.start();
        i2c_master_model_i.xbyte(8'hca, q, a);
        chk("foreign", 1, a);
        live = 80'({rnd(), rnd(), rnd()});
        ptr(SUB_C);
        rd(live.c);
        busy_in = 1'b1;
        pulse(done_in);
        keep = live;
        live = 80'({rnd(), rnd(), rnd()});
        rd(keep.c);
        busy_in = 1'b0;
        pulse(alarm_in);
        chk("irq", 0, irq_n_out);
        keep = live;
        live = 80'({rnd(), rnd(), rnd()});
        rd({live.c[15:4], keep.c[3:0]});
        pulse(irq_clear_in);
        @(negedge clock_in);
        chk("irq", 1, irq_n_out);
        rd(live.c);
        ptr(SUB_E);
        rd(live.e);
        i2c_master_model_i.stop();
        end_sim();
    end
endmodule : i2c_pending_access_test
`default_nettype wire
